/* hdl/uartrb_top.sv */
// UART channel: byte-wide host registers, baud generator, serial line.
// Assumes host strobes on the core clock and an asynchronous serial input.
`include "uartrb_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module uartrb_top (
   input  wire logic                 clock,
   input  wire logic                 rst_n,
   input  wire logic [2:0]           addr,
   input  wire logic                 wr_strobe,
   input  wire logic                 rd_strobe,
   input  wire uartrb_pkg::uartrb_byte_t wr_data,
   output var  uartrb_pkg::uartrb_byte_t rd_data,
   input  wire logic                 serial_in,
   output var  logic                 serial_out,
   input  wire logic [3:0]           modem_in_n,
   output var  logic [3:0]           modem_out_n,
   output var  uartrb_pkg::uartrb_byte_t indexed_sel,
   output var  logic [1:0]           rx_trigger,
   output var  logic [1:0]           tx_trigger
);
   import uartrb_pkg::*;

   uartrb_byte_t     lctl_reg, mctl_reg, mask_reg, fctl_reg, tx_hold_reg;
   uartrb_byte_t     rx_hold_reg, rd_data_reg, rd_data_next;
   logic [15:0]      div_reg, bcnt_reg;
   logic             baud_tick, dlab, tx_launch;
   logic             hold_full_reg, ready_reg, overrun_reg, perr_reg;
   logic             ferr_reg, brk_reg, rx_done;
   logic [3:0]       mst_delta_reg, mst_s1_reg, mst_s2_reg, mst_old_reg;
   logic             rx_s1_reg, rx_s2_reg;
   uartrb_tx_e       tx_state_reg;
   uartrb_rx_e       rx_state_reg;
   logic [11:0]      tx_shift_reg, tx_frame;
   logic [3:0]       tx_bits_reg, tx_tick_reg, tx_len;
   logic [3:0]       rx_tick_reg, rx_idx_reg, dlen;
   logic [8:0]       rx_shift_reg;
   logic             par_bit;
   logic             wr_data_hit, rd_data_hit;

   assign dlab        = lctl_reg[`UARTRB_LCT_DLAB];
   assign dlen        = `UARTRB_MIN_LEN + {2'h0, lctl_reg[1:0]};
   assign wr_data_hit = wr_strobe && addr == `UARTRB_OFF_DATA && !dlab;
   assign rd_data_hit = rd_strobe && addr == `UARTRB_OFF_DATA && !dlab;

   // Parity over the active data bits
   function automatic logic parity_of(input logic [7:0] d,
                                      input logic [7:0] ctl);
      logic       p;
      logic [3:0] n;
      p = 1'b0;
      n = `UARTRB_MIN_LEN + {2'h0, ctl[1:0]};
      for (int i = 0; i < 8; i++) begin
         if (i < 32'(n)) begin
            p = p ^ d[i];
         end
      end
      if (ctl[`UARTRB_LCT_FORCE]) begin
         parity_of = ~ctl[`UARTRB_LCT_EVEN];
      end else begin
         parity_of = ctl[`UARTRB_LCT_EVEN] ? p : ~p;
      end
   endfunction

   // Host writes
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         lctl_reg <= `UARTRB_LCT_RESET;
         div_reg  <= `UARTRB_DIV_RESET;
         mctl_reg <= 8'h00;
         mask_reg <= 8'h00;
         fctl_reg <= 8'h00;
         indexed_sel <= 8'h00;
      end else if (wr_strobe) begin
         case (addr)
            `UARTRB_OFF_DATA: if (dlab) div_reg[7:0] <= wr_data;
            `UARTRB_OFF_MASK: begin
               if (dlab) begin
                  div_reg[15:8] <= wr_data;
               end else begin
                  mask_reg <= wr_data;
               end
            end
            `UARTRB_OFF_FIFO: fctl_reg <= wr_data;
            `UARTRB_OFF_LCT:  lctl_reg <= wr_data;
            `UARTRB_OFF_MCT:  mctl_reg <= wr_data;
            `UARTRB_OFF_SCR:  indexed_sel <= wr_data;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rx_trigger  <= 2'h0;
         tx_trigger  <= 2'h0;
         modem_out_n <= 4'hF;
      end else begin
         rx_trigger  <= fctl_reg[7:6];
         tx_trigger  <= fctl_reg[5:4];
         modem_out_n <= ~mctl_reg[3:0];
      end
   end

   // Baud generator, one tick per divisor clocks
   // Catches up at once when the divisor shrinks below the count
   assign baud_tick = div_reg != 16'h0000 && bcnt_reg >= div_reg - 16'h0001;
   // Frames start on a tick so the start bit is a full cell
   assign tx_launch = tx_state_reg == TX_IDLE && hold_full_reg
                      && !wr_data_hit && baud_tick;

   always_ff @(posedge clock) begin
      if (!rst_n || baud_tick) begin
         bcnt_reg <= 16'h0000;
      end else if (div_reg != 16'h0000) begin
         bcnt_reg <= bcnt_reg + 16'h0001;
      end
   end

   // Transmit frame image, start bit in bit 0
   always_comb begin
      par_bit  = parity_of(tx_hold_reg, lctl_reg);
      tx_frame = 12'hFFF;
      tx_frame[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (i < 32'(dlen)) begin
            tx_frame[i + 1] = tx_hold_reg[i];
         end
      end
      if (lctl_reg[`UARTRB_LCT_PEN]) begin
         tx_frame[dlen + 4'h1] = par_bit;
      end
      tx_len = dlen + 4'h2 + {3'h0, lctl_reg[`UARTRB_LCT_PEN]}
             + {3'h0, lctl_reg[`UARTRB_LCT_STOP]};
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         tx_hold_reg <= 8'h00;
      end else if (wr_data_hit) begin
         tx_hold_reg <= wr_data;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         hold_full_reg <= 1'b0;
      end else if (wr_data_hit) begin
         hold_full_reg <= 1'b1;
      end else if (tx_launch) begin
         hold_full_reg <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         tx_state_reg <= TX_IDLE;
         tx_shift_reg <= 12'hFFF;
         tx_bits_reg  <= 4'h0;
         tx_tick_reg  <= 4'h0;
      end else begin
         case (tx_state_reg)
            TX_IDLE: begin
               if (tx_launch) begin
                  tx_shift_reg <= tx_frame;
                  tx_bits_reg  <= tx_len;
                  tx_tick_reg  <= 4'h0;
                  tx_state_reg <= TX_SEND;
               end
            end
            TX_SEND: begin
               if (baud_tick) begin
                  tx_tick_reg <= tx_tick_reg + 4'h1;
                  if (tx_tick_reg == `UARTRB_FULL_BIT) begin
                     tx_shift_reg <= {1'b1, tx_shift_reg[11:1]};
                     tx_bits_reg  <= tx_bits_reg - 4'h1;
                     if (tx_bits_reg == 4'h1) begin
                        tx_state_reg <= TX_IDLE;
                     end
                  end
               end
            end
            default: tx_state_reg <= TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         serial_out <= 1'b1;
      end else if (lctl_reg[`UARTRB_LCT_BREAK]) begin
         serial_out <= 1'b0;
      end else begin
         serial_out <= tx_state_reg == TX_SEND ? tx_shift_reg[0] : 1'b1;
      end
   end

   // Input synchronisers
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rx_s1_reg  <= 1'b1;
         rx_s2_reg  <= 1'b1;
         mst_s1_reg <= 4'hF;
         mst_s2_reg <= 4'hF;
      end else begin
         rx_s1_reg  <= serial_in;
         rx_s2_reg  <= rx_s1_reg;
         mst_s1_reg <= modem_in_n;
         mst_s2_reg <= mst_s1_reg;
      end
   end

   // Receiver, start checked at mid bit then one sample per bit
   assign rx_done = rx_state_reg == RX_STOP && baud_tick
                    && rx_tick_reg == `UARTRB_FULL_BIT;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rx_state_reg <= RX_IDLE;
         rx_tick_reg  <= 4'h0;
         rx_idx_reg   <= 4'h0;
         rx_shift_reg <= 9'h000;
      end else if (baud_tick) begin
         rx_tick_reg <= rx_tick_reg + 4'h1;
         case (rx_state_reg)
            RX_IDLE: begin
               rx_tick_reg <= 4'h0;
               if (!rx_s2_reg) begin
                  rx_state_reg <= RX_START;
               end
            end
            RX_START: begin
               if (rx_tick_reg == `UARTRB_HALF_BIT) begin
                  rx_tick_reg  <= 4'h0;
                  rx_idx_reg   <= 4'h0;
                  rx_shift_reg <= 9'h000;
                  rx_state_reg <= rx_s2_reg ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (rx_tick_reg == `UARTRB_FULL_BIT) begin
                  rx_shift_reg[rx_idx_reg] <= rx_s2_reg;
                  rx_idx_reg <= rx_idx_reg + 4'h1;
                  if (rx_idx_reg + 4'h1 ==
                      dlen + {3'h0, lctl_reg[`UARTRB_LCT_PEN]}) begin
                     rx_state_reg <= RX_STOP;
                  end
               end
            end
            RX_STOP: if (rx_done) rx_state_reg <= RX_IDLE;
            default: rx_state_reg <= RX_IDLE;
         endcase
      end
   end

   // Received byte and line status; a new event beats a clearing read
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rx_hold_reg <= 8'h00;
         ready_reg   <= 1'b0;
         overrun_reg <= 1'b0;
         perr_reg    <= 1'b0;
         ferr_reg    <= 1'b0;
         brk_reg     <= 1'b0;
      end else if (rx_done) begin
         rx_hold_reg <= rx_shift_reg[7:0] & ((8'h01 << dlen) - 8'h01);
         ready_reg   <= 1'b1;
         overrun_reg <= overrun_reg || ready_reg;
         perr_reg    <= lctl_reg[`UARTRB_LCT_PEN] && rx_shift_reg[dlen]
                        != parity_of(rx_shift_reg[7:0], lctl_reg);
         ferr_reg    <= !rx_s2_reg;
         brk_reg     <= !rx_s2_reg && rx_shift_reg == 9'h000;
      end else begin
         if (rd_data_hit) begin
            ready_reg <= 1'b0;
         end
         if (rd_strobe && addr == `UARTRB_OFF_LST) begin
            overrun_reg <= 1'b0;
            perr_reg    <= 1'b0;
            ferr_reg    <= 1'b0;
            brk_reg     <= 1'b0;
         end
      end
   end

   // Modem status deltas, cleared by reading, change wins
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         mst_old_reg   <= 4'hF;
         mst_delta_reg <= 4'h0;
      end else begin
         mst_old_reg <= mst_s2_reg;
         if (rd_strobe && addr == `UARTRB_OFF_MST) begin
            mst_delta_reg <= mst_s2_reg ^ mst_old_reg;
         end else begin
            mst_delta_reg <= mst_delta_reg | (mst_s2_reg ^ mst_old_reg);
         end
      end
   end

   // Read mux
   always_comb begin
      case (addr)
         `UARTRB_OFF_DATA: rd_data_next = dlab ? div_reg[7:0]
                                               : rx_hold_reg;
         `UARTRB_OFF_MASK: rd_data_next = dlab ? div_reg[15:8] : mask_reg;
         `UARTRB_OFF_FIFO: rd_data_next = `UARTRB_INT_NONE;
         `UARTRB_OFF_LCT:  rd_data_next = lctl_reg;
         `UARTRB_OFF_MCT:  rd_data_next = mctl_reg;
         `UARTRB_OFF_LST:  rd_data_next = {perr_reg | ferr_reg | brk_reg,
                              tx_state_reg == TX_IDLE && !hold_full_reg,
                              !hold_full_reg, brk_reg, ferr_reg, perr_reg,
                              overrun_reg, ready_reg};
         `UARTRB_OFF_MST:  rd_data_next = {~mst_s2_reg, mst_delta_reg};
         `UARTRB_OFF_SCR:  rd_data_next = indexed_sel;
         default:          rd_data_next = 8'h00;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rd_data_reg <= 8'h00;
      end else if (rd_strobe) begin
         rd_data_reg <= rd_data_next;
      end
   end
   assign rd_data = rd_data_reg;

   // Checks
   logic [15:0] gap_reg;
   logic        gap_ok_reg;
   always_ff @(posedge clock) begin
      if (!rst_n || baud_tick) begin
         gap_reg <= 16'h0000;
      end else begin
         gap_reg <= gap_reg + 16'h0001;
      end
   end
   always_ff @(posedge clock) begin
      if (!rst_n || (wr_strobe && dlab)) begin
         gap_ok_reg <= 1'b0;
      end else if (baud_tick) begin
         gap_ok_reg <= 1'b1;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_tick_period: assert property (baud_tick && gap_ok_reg |->
      gap_reg == div_reg - 16'h0001) else $error("baud tick period wrong");
   a_div_low: assert property (wr_strobe && dlab
      && addr == `UARTRB_OFF_DATA |=> div_reg[7:0] == $past(wr_data))
      else $error("divisor low not loaded");
   a_hold_loads: assert property (wr_data_hit |=>
      !rd_data_next[5] || addr != `UARTRB_OFF_LST)
      else $error("holding not full");
   a_rx_read_clr: assert property (rd_data_hit && !rx_done |=>
      !ready_reg) else $error("ready not cleared by read");
   a_scratch_keep: assert property (wr_strobe
      && addr == `UARTRB_OFF_SCR |=> indexed_sel == $past(wr_data))
      else $error("scratch not kept");
   a_fifo_fields: assert property (wr_strobe
      && addr == `UARTRB_OFF_FIFO |=> ##1
      rx_trigger == $past(wr_data[7:6], 2)) else $error("rx trigger wrong");
   a_break_low: assert property (lctl_reg[`UARTRB_LCT_BREAK]
      |=> !serial_out) else $error("break not driven");
   a_overrun_set: assert property (rx_done && ready_reg |=>
      overrun_reg [*1] ##0 ready_reg) else $error("overrun missed");

   c_tx_frame: cover property (tx_state_reg == TX_SEND ##1
      tx_state_reg == TX_IDLE);
   c_rx_byte: cover property (rx_done ##[1:50] rd_data_hit);
   c_div_set: cover property (wr_strobe && dlab && addr == 3'h1);
endmodule
`default_nettype wire

/* hdl/uartrb_cfg.svh */
// Constants of the UART register file and baud generator.
// Assumes a single clock that also serves as the baud reference.
// How it works
// - With divisor access off, a write at offset 0 queues a byte to send and a read returns the received byte.
// - With line-control bit 7 set, offsets 0 and 1 reach the low and high divisor bytes.
// - Offset 7 keeps whatever software last wrote there.
// - The byte at offset 7 also selects the indexed control register.
// - The write-only FIFO control at offset 2 holds receive and transmit trigger fields, flush bits and enable.
// - The baud generator divides the reference by the divisor to make a 16x tick.
// - At 14.7456 MHz divisor 96 gives 9600 baud, 8 gives 115200, 16 serves 56000 and 57600.
// - At 16 MHz divisor 8 gives 125000 baud.
// - At 16 MHz divisor 4 gives 250000 baud.
`ifndef UARTRB_CFG_SVH
`define UARTRB_CFG_SVH
`define UARTRB_OFF_DATA    3'h0
`define UARTRB_OFF_MASK    3'h1
`define UARTRB_OFF_FIFO    3'h2
`define UARTRB_OFF_LCT     3'h3
`define UARTRB_OFF_MCT     3'h4
`define UARTRB_OFF_LST     3'h5
`define UARTRB_OFF_MST     3'h6
`define UARTRB_OFF_SCR     3'h7
`define UARTRB_LCT_DLAB    7
`define UARTRB_LCT_BREAK   6
`define UARTRB_LCT_FORCE   5
`define UARTRB_LCT_EVEN    4
`define UARTRB_LCT_PEN     3
`define UARTRB_LCT_STOP    2
`define UARTRB_INT_NONE    8'h01
`define UARTRB_LCT_RESET   8'h03
`define UARTRB_DIV_RESET   16'h0060
`define UARTRB_MIN_LEN     4'h5
`define UARTRB_HALF_BIT    4'h7
`define UARTRB_FULL_BIT    4'hF
`endif

/* hdl/uartrb_pkg.sv */
// Types of the UART register file and baud generator.
// Assumes the constants header is included by the top module.
package uartrb_pkg;
   typedef enum logic [3:0] {
      RX_IDLE  = 4'b0001,
      RX_START = 4'b0010,
      RX_DATA  = 4'b0100,
      RX_STOP  = 4'b1000
   } uartrb_rx_e;
   typedef enum logic [1:0] {
      TX_IDLE = 2'b01,
      TX_SEND = 2'b10
   } uartrb_tx_e;
   typedef logic [7:0] uartrb_byte_t;
endpackage

/* tb/uartrb_remote.sv */
// Remote serial device: sends frames on request, decodes what it hears.
// Assumes 8 data bits, no parity, one stop bit; bench sets the bit length.
`timescale 1ns/10ps
`default_nettype none
module uartrb_remote (
   input  wire logic clock,
   input  wire logic line_rx,
   output var  logic line_tx
);
   int         bit_clks = 64;
   int         rx_count = 0;
   int         low_len  = 0;
   logic [7:0] rx_byte;
   logic       rx_stop;
   initial line_tx = 1'b1;
   // Start bit, data LSB first, then stop; line rests high after
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         line_tx <= f[i];
         repeat (bit_clks) @(posedge clock);
      end
   endtask
   // Start length measured, bits sampled mid-cell
   always begin : decode
      int   k;
      logic run;
      @(posedge clock);
      if (line_rx === 1'b0) begin
         run = 1'b1;
         low_len = 1;
         for (k = 1; k <= 9 * bit_clks + bit_clks / 2; k++) begin
            @(posedge clock);
            if (line_rx !== 1'b0) run = 1'b0;
            else if (run) low_len++;
            if (k > bit_clks && k < 9 * bit_clks &&
                k % bit_clks == bit_clks / 2)
               rx_byte[k / bit_clks - 1] = line_rx;
         end
         rx_stop = line_rx;
         rx_count++;
      end
   end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Bench for the UART channel: register tasks and remote line partner.
// Assumes the core clock is also the baud reference.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import uartrb_pkg::*;
   logic         clock     = 1'b0;
   logic         rst_n     = 1'b0;
   logic [2:0]   addr      = 3'h0;
   logic         wr_strobe = 1'b0;
   logic         rd_strobe = 1'b0;
   uartrb_byte_t wr_data   = 8'h00;
   uartrb_byte_t rd_data;
   logic         serial_in;
   logic         serial_out;
   logic [3:0]   modem_out_n;
   uartrb_byte_t indexed_sel;
   logic [1:0]   rx_trigger;
   logic [1:0]   tx_trigger;
   int           n_mismatch  = 0;
   int           checks_done = 0;
   int           divs [4]    = '{96, 16, 8, 4};
   always #4 clock = ~clock;
   uartrb_top u_uartrb_top (
      .clock      (clock),
      .rst_n      (rst_n),
      .addr       (addr),
      .wr_strobe  (wr_strobe),
      .rd_strobe  (rd_strobe),
      .wr_data    (wr_data),
      .rd_data    (rd_data),
      .serial_in  (serial_in),
      .serial_out (serial_out),
      .modem_in_n (4'hF),
      .modem_out_n(modem_out_n),
      .indexed_sel(indexed_sel),
      .rx_trigger (rx_trigger),
      .tx_trigger (tx_trigger)
   );
   uartrb_remote u_uartrb_remote (
      .clock  (clock),
      .line_rx(serial_out),
      .line_tx(serial_in)
   );
   task automatic wrap_up;
      $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [2:0] a, input uartrb_byte_t d);
      @(negedge clock);
      addr = a;
      wr_data = d;
      wr_strobe = 1'b1;
      @(negedge clock);
      wr_strobe = 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output uartrb_byte_t d);
      @(negedge clock);
      addr = a;
      rd_strobe = 1'b1;
      @(negedge clock);
      rd_strobe = 1'b0;
      d = rd_data;
   endtask
   task automatic rchk(input logic [2:0] a, input uartrb_byte_t e,
                       input string what);
      uartrb_byte_t d;
      rd(a, d);
      chk(what, d, e);
   endtask
   task automatic set_div(input int dv);
      wr(3'h3, 8'h83);
      wr(3'h0, 8'(dv));
      wr(3'h1, 8'(dv >> 8));
      wr(3'h3, 8'h03);
      u_uartrb_remote.bit_clks = 16 * dv;
   endtask
   // Bounded wait for the partner to finish frame n
   task automatic wait_rx(input int n);
      for (int i = 0; i < 40000 && u_uartrb_remote.rx_count < n; i++)
         @(negedge clock);
      if (u_uartrb_remote.rx_count < n) begin
         n_mismatch++;
         wrap_up();
      end
   endtask
   // Polls line status until a byte is ready; returns the status seen
   task automatic wait_ready(output uartrb_byte_t d);
      d = 8'h00;
      for (int i = 0; i < 300 && d[0] !== 1'b1; i++) rd(3'h5, d);
      if (d[0] !== 1'b1) begin
         n_mismatch++;
         wrap_up();
      end
   endtask
   initial begin : main
      int           n;
      uartrb_byte_t s;
      repeat (16) @(negedge clock);
      rst_n = 1'b1;
      rchk(3'h3, 8'h03, "line_control");
      rchk(3'h5, 8'h60, "line_status");
      wr(3'h3, 8'h83);
      rchk(3'h0, 8'h60, "divisor_low");
      rchk(3'h1, 8'h00, "divisor_high");
      wr(3'h1, 8'h5A);
      wr(3'h3, 8'h03);
      wr(3'h1, 8'h0F);
      rchk(3'h1, 8'h0F, "interrupt_mask");
      wr(3'h3, 8'h83);
      rchk(3'h1, 8'h5A, "divisor_high");
      // Break: every field but divisor access set, line forced low
      wr(3'h3, 8'h7F);
      rchk(3'h3, 8'h7F, "line_control");
      repeat (4) @(negedge clock);
      chk("break_line", {7'h00, serial_out}, 8'h00);
      wr(3'h3, 8'h03);
      repeat (1000) @(negedge clock);
      chk("idle_line", {7'h00, serial_out}, 8'h01);
      wr(3'h7, 8'hA5);
      rchk(3'h7, 8'hA5, "scratch_index");
      chk("indexed_sel", indexed_sel, 8'hA5);
      wr(3'h2, 8'hD0);
      repeat (3) @(negedge clock);
      chk("rx_trigger", {6'h00, rx_trigger}, 8'h03);
      chk("tx_trigger", {6'h00, tx_trigger}, 8'h01);
      rchk(3'h2, 8'h01, "interrupt_source");
      // Modem control drives the active-low outputs
      wr(3'h4, 8'h0B);
      repeat (3) @(negedge clock);
      chk("modem_out_n", {4'h0, modem_out_n}, 8'h04);
      rchk(3'h4, 8'h0B, "modem_control");
      // Bit length per divisor; first byte bit set so start is exact
      foreach (divs[i]) begin
         set_div(divs[i]);
         n = u_uartrb_remote.rx_count + 1;
         wr(3'h0, 8'(8'h55 + 2 * i));
         wait_rx(n);
         chk("tx_byte", u_uartrb_remote.rx_byte, 8'(8'h55 + 2 * i));
         chk("bit_len_err", 8'(u_uartrb_remote.low_len - 16 * divs[i]),
             8'h00);
         chk("stop", {7'h00, u_uartrb_remote.rx_stop}, 8'h01);
      end
      // Seven data bits: the stop bit lands in the eighth cell
      wr(3'h3, 8'h02);
      n = u_uartrb_remote.rx_count + 1;
      wr(3'h0, 8'h00);
      wait_rx(n);
      chk("seven_bit", u_uartrb_remote.rx_byte, 8'h80);
      // Even parity bit lands in the cell the partner takes as stop
      wr(3'h3, 8'h1B);
      n = u_uartrb_remote.rx_count + 1;
      wr(3'h0, 8'h03);
      wait_rx(n);
      chk("parity_byte", u_uartrb_remote.rx_byte, 8'h03);
      chk("even_parity", {7'h00, u_uartrb_remote.rx_stop}, 8'h00);
      wr(3'h3, 8'h03);
      // Receive kept at the highest guaranteed rate
      set_div(8);
      u_uartrb_remote.send_byte(8'h3C);
      wait_ready(s);
      chk("line_status", s, 8'h61);
      rchk(3'h0, 8'h3C, "rx_holding");
      rchk(3'h5, 8'h60, "line_status");
      u_uartrb_remote.send_byte(8'h11);
      u_uartrb_remote.send_byte(8'h22);
      wait_ready(s);
      chk("overrun", s, 8'h63);
      rchk(3'h0, 8'h22, "rx_holding");
      wrap_up();
   end
endmodule
`default_nettype wire
